// File: rtl/video_window_pkg.sv
// constants for the video window geometry register slice
package video_window_pkg;

    // ****************************************
    // register indices behind the data port
    // ****************************************
    localparam logic [7:0] IDX_REGION1_LOW = 8'h33;
    localparam logic [7:0] IDX_REGION2_WIDTH_LOW = 8'h34;
    localparam logic [7:0] IDX_REGION2_SRC_LOW = 8'h35;
    localparam logic [7:0] IDX_HORIZ_OVF = 8'h36;
    localparam logic [7:0] IDX_TOP_LINE_LOW = 8'h37;
    localparam logic [7:0] IDX_BOTTOM_LINE_LOW = 8'h38;
    localparam logic [7:0] IDX_VERT_OVF = 8'h39;
    localparam logic [7:0] IDX_BUF1_BYTE0 = 8'h3A;
    localparam logic [7:0] IDX_BUF1_BYTE1 = 8'h3B;
    localparam logic [7:0] IDX_BUF1_HIGH = 8'h3C;
    localparam logic [7:0] IDX_CAPTURE_MISC = 8'h58;
    localparam logic [7:0] IDX_BUF2_BYTE0 = 8'h59;
    localparam logic [7:0] IDX_BUF2_BYTE1 = 8'h5A;
    localparam logic [7:0] IDX_PIXEL_ALIGN = 8'h5D;

    // ****************************************
    // field positions
    // ****************************************
    localparam int HOVF_REGION1_LSB = 0;
    localparam int HOVF_REGION2_WIDTH_LSB = 2;
    localparam int HOVF_REGION2_SRC_LSB = 4;
    localparam int VOVF_TOP_LSB = 0;
    localparam int VOVF_BOTTOM_LSB = 2;
    localparam int ALIGN_ADDR_LSB = 2;
    localparam int ALIGN_SKIP_LSB = 0;

    // ****************************************
    // widths, values after reset and the value read at an unmapped index
    // ****************************************
    localparam int GEOM_W = 10;
    localparam int ADDR_W = 22;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [5:0] HOVF_RESET = 6'h00;
    localparam logic [3:0] NIBBLE_RESET = 4'h0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // scan phases along one scanline, Gray coded
    typedef enum logic [1:0] {
        PH_REGION1 = 2'b00,
        PH_REGION2 = 2'b01,
        PH_REGION3 = 2'b11
    } scan_phase_t;

endpackage

// File: rtl/window_scan_tracker.sv
// scanline and dword position tracker for the video window
`timescale 1ns/1ps
`default_nettype none
module window_scan_tracker #(
    parameter int GW = 10
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic frameStart,
    input wire logic lineStart,
    input wire logic dwordSlot,
    input wire logic videoSlot,
    input wire logic [GW-1:0] region1Size,
    input wire logic [GW-1:0] region2Width,
    input wire logic [GW-1:0] region2SourceDwords,
    input wire logic [GW-1:0] windowTopLine,
    input wire logic [GW-1:0] windowBottomLine,
    output logic windowLine,
    output logic windowShow,
    output logic graphicsFetch,
    output logic videoFetch
);

    typedef struct packed {
        logic [GW-1:0] line;
        logic [GW-1:0] dpos;
        logic [GW-1:0] srcLeft;
        video_window_pkg::scan_phase_t phase;
    } track_t;

    track_t cur_reg, cur_next;
    logic [GW-1:0] lineNew;
    logic inRangeNew;

    // window lines bound inclusively by top and bottom
    assign windowLine = (cur_reg.line >= windowTopLine) &&
                        (cur_reg.line <= windowBottomLine);
    assign windowShow = windowLine &&
                        (cur_reg.phase == video_window_pkg::PH_REGION2);
    // region 2 dwords are skipped, never sent to the fifo
    assign graphicsFetch = dwordSlot &&
                           (cur_reg.phase != video_window_pkg::PH_REGION2);
    assign videoFetch = videoSlot && (cur_reg.srcLeft != '0);

    // next state of the scan position
    always_comb begin
        cur_next = cur_reg;
        lineNew = frameStart ? '0 : GW'(cur_reg.line + 1'b1);
        inRangeNew = (lineNew >= windowTopLine) &&
                     (lineNew <= windowBottomLine);
        if (frameStart || lineStart) begin
            cur_next.line = lineNew;
            cur_next.dpos = '0;
            cur_next.srcLeft = inRangeNew ? region2SourceDwords : '0;
            // an empty region 1 puts the window at the left edge
            if (inRangeNew && region1Size == '0 && region2Width != '0) begin
                cur_next.phase = video_window_pkg::PH_REGION2;
            end else begin
                cur_next.phase = video_window_pkg::PH_REGION1;
            end
        end else begin
            if (videoFetch) begin
                cur_next.srcLeft = GW'(cur_reg.srcLeft - 1'b1);
            end
            if (dwordSlot) begin
                cur_next.dpos = GW'(cur_reg.dpos + 1'b1);
                unique case (cur_reg.phase)
                    video_window_pkg::PH_REGION1: begin
                        // left edge follows the last region 1 dword
                        if (windowLine && region2Width != '0 &&
                            cur_next.dpos == region1Size) begin
                            cur_next.phase = video_window_pkg::PH_REGION2;
                            cur_next.dpos = '0;
                        end
                    end
                    video_window_pkg::PH_REGION2: begin
                        if (cur_next.dpos == region2Width) begin
                            cur_next.phase = video_window_pkg::PH_REGION3;
                            cur_next.dpos = '0;
                        end
                    end
                    video_window_pkg::PH_REGION3: begin
                    end
                    default: begin
                        cur_next.phase = video_window_pkg::PH_REGION1;
                    end
                endcase
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cur_reg <= '{line: '0, dpos: '0, srcLeft: '0,
                         phase: video_window_pkg::PH_REGION1};
        end else begin
            cur_reg <= cur_next;
        end
    end

endmodule
`default_nettype wire

// File: rtl/video_window_geometry_regs.sv
// video window geometry and buffer address registers
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - region 2 source size: 10-bit dword count fetched per window line
// - region 2 width: low byte plus horizontal overflow bits 3:2
// - region 1 size: low byte plus horizontal overflow bits 1:0
// - vertical start is the first scanline holding the window
// - vertical start: low byte plus vertical overflow bits 1:0
// - vertical end is the last scanline holding the window
// - vertical end: low byte plus overflow bits 3:2; bits 7:4 reserved
// - buffer 1 bits 9:2 and 17:10 come from two byte registers
// - buffer 1 bits 21:18 from high byte, 1:0 from alignment 3:2
// - buffer 2 address built the same way from its own registers and the shared alignment bits 3:2
// - buffer 1 displays by default; double buffering alternates roles
// - both buffer starts are byte addresses in 4-Mbyte memory
// - capture writes dword aligned; low alignment bits only for display
// - region 1 counts graphics dwords up to the window left edge
// - region 2 width dwords of background are skipped per window line
module video_window_geometry_regs (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic ioSel,
    input wire logic ioWr,
    input wire logic ioRd,
    input wire logic [7:0] ioWdata,
    output logic [7:0] ioRdata,
    input wire logic dblBufEn,
    input wire logic bufferFlip,
    input wire logic frameStart,
    input wire logic lineStart,
    input wire logic dwordSlot,
    input wire logic videoSlot,
    output logic [9:0] region1Size,
    output logic [9:0] region2Width,
    output logic [9:0] region2SourceDwords,
    output logic [9:0] windowTopLine,
    output logic [9:0] windowBottomLine,
    output logic [21:0] buffer1Start,
    output logic [21:0] buffer2Start,
    output logic [21:0] displayBase,
    output logic [21:0] captureBase,
    output logic [1:0] displayPixelSkip,
    output logic displayIsBuffer2,
    output logic windowLine,
    output logic windowShow,
    output logic graphicsFetch,
    output logic videoFetch
);

    // ****************************************
    // state
    // ****************************************

    // every register of the slice, held in one record
    typedef struct packed {
        logic [7:0] index;
        logic [7:0] region1Low;
        logic [7:0] region2WidthLow;
        logic [7:0] region2SrcLow;
        logic [5:0] horizOvf;
        logic [7:0] topLineLow;
        logic [7:0] bottomLineLow;
        logic [3:0] vertOvf;
        logic [7:0] buf1Byte0;
        logic [7:0] buf1Byte1;
        logic [3:0] buf1High;
        logic [3:0] captureMiscLow;
        logic [7:0] buf2Byte0;
        logic [7:0] buf2Byte1;
        logic [3:0] pixelAlign;
        logic [7:0] readData;
        logic dispSel;
    } regs_t;

    regs_t st_reg, st_next;
    logic [7:0] readValue;
    logic dataWrite;

    assign dataWrite = ioWr && ioSel;

    // ****************************************
    // field assembly
    // ****************************************

    // horizontal fields widen to 10 bits from the overflow register
    assign region2SourceDwords = {
        st_reg.horizOvf[video_window_pkg::HOVF_REGION2_SRC_LSB +: 2],
        st_reg.region2SrcLow};
    assign region2Width = {
        st_reg.horizOvf[video_window_pkg::HOVF_REGION2_WIDTH_LSB +: 2],
        st_reg.region2WidthLow};
    assign region1Size = {
        st_reg.horizOvf[video_window_pkg::HOVF_REGION1_LSB +: 2],
        st_reg.region1Low};

    // vertical bounds widen from the vertical overflow register
    assign windowTopLine = {
        st_reg.vertOvf[video_window_pkg::VOVF_TOP_LSB +: 2],
        st_reg.topLineLow};
    assign windowBottomLine = {
        st_reg.vertOvf[video_window_pkg::VOVF_BOTTOM_LSB +: 2],
        st_reg.bottomLineLow};

    // byte addresses; the alignment pair fills the lowest two bits
    assign buffer1Start = {
        st_reg.buf1High,
        st_reg.buf1Byte1,
        st_reg.buf1Byte0,
        st_reg.pixelAlign[video_window_pkg::ALIGN_ADDR_LSB +: 2]
    };
    assign buffer2Start = {
        st_reg.captureMiscLow,
        st_reg.buf2Byte1,
        st_reg.buf2Byte0,
        st_reg.pixelAlign[video_window_pkg::ALIGN_ADDR_LSB +: 2]
    };

    // ****************************************
    // buffer roles
    // ****************************************

    // buffer 1 displays unless a flip has swapped the roles
    assign displayIsBuffer2 = st_reg.dispSel;
    assign displayBase = st_reg.dispSel ? buffer2Start : buffer1Start;
    // capture is forced onto a dword boundary
    assign captureBase = st_reg.dispSel ?
        {buffer1Start[21:2], 2'b00} :
        {buffer2Start[21:2], 2'b00};
    // the pixel skip pair reaches display reads only
    assign displayPixelSkip =
        st_reg.pixelAlign[video_window_pkg::ALIGN_SKIP_LSB +: 2];

    assign ioRdata = st_reg.readData;

    // ****************************************
    // register read view
    // ****************************************

    // reserved and foreign bits read as zero
    always_comb begin
        case (st_reg.index)
            video_window_pkg::IDX_REGION1_LOW: begin
                readValue = st_reg.region1Low;
            end

            video_window_pkg::IDX_REGION2_WIDTH_LOW: begin
                readValue = st_reg.region2WidthLow;
            end

            video_window_pkg::IDX_REGION2_SRC_LOW: begin
                readValue = st_reg.region2SrcLow;
            end

            video_window_pkg::IDX_HORIZ_OVF: begin
                readValue = {2'b00, st_reg.horizOvf};
            end

            video_window_pkg::IDX_TOP_LINE_LOW: begin
                readValue = st_reg.topLineLow;
            end

            video_window_pkg::IDX_BOTTOM_LINE_LOW: begin
                readValue = st_reg.bottomLineLow;
            end

            video_window_pkg::IDX_VERT_OVF: begin
                readValue = {4'h0, st_reg.vertOvf};
            end

            video_window_pkg::IDX_BUF1_BYTE0: begin
                readValue = st_reg.buf1Byte0;
            end

            video_window_pkg::IDX_BUF1_BYTE1: begin
                readValue = st_reg.buf1Byte1;
            end

            video_window_pkg::IDX_BUF1_HIGH: begin
                readValue = {4'h0, st_reg.buf1High};
            end

            video_window_pkg::IDX_CAPTURE_MISC: begin
                readValue = {4'h0, st_reg.captureMiscLow};
            end

            video_window_pkg::IDX_BUF2_BYTE0: begin
                readValue = st_reg.buf2Byte0;
            end

            video_window_pkg::IDX_BUF2_BYTE1: begin
                readValue = st_reg.buf2Byte1;
            end

            video_window_pkg::IDX_PIXEL_ALIGN: begin
                readValue = {4'h0, st_reg.pixelAlign};
            end
            default: begin
                readValue = video_window_pkg::READ_UNMAPPED;
            end
        endcase
    end

    // ****************************************
    // next state
    // ****************************************

    // index port selects, data port stores into the selected register
    always_comb begin
        st_next = st_reg;
        if (ioWr && !ioSel) begin
            st_next.index = ioWdata;
        end
        if (dataWrite) begin
            case (st_reg.index)
                video_window_pkg::IDX_REGION1_LOW: begin
                    st_next.region1Low = ioWdata;
                end

                video_window_pkg::IDX_REGION2_WIDTH_LOW: begin
                    st_next.region2WidthLow = ioWdata;
                end

                video_window_pkg::IDX_REGION2_SRC_LOW: begin
                    st_next.region2SrcLow = ioWdata;
                end

                video_window_pkg::IDX_HORIZ_OVF: begin
                    st_next.horizOvf = ioWdata[5:0];
                end

                video_window_pkg::IDX_TOP_LINE_LOW: begin
                    st_next.topLineLow = ioWdata;
                end

                video_window_pkg::IDX_BOTTOM_LINE_LOW: begin
                    st_next.bottomLineLow = ioWdata;
                end

                video_window_pkg::IDX_VERT_OVF: begin
                    st_next.vertOvf = ioWdata[3:0];
                end

                video_window_pkg::IDX_BUF1_BYTE0: begin
                    st_next.buf1Byte0 = ioWdata;
                end

                video_window_pkg::IDX_BUF1_BYTE1: begin
                    st_next.buf1Byte1 = ioWdata;
                end

                video_window_pkg::IDX_BUF1_HIGH: begin
                    st_next.buf1High = ioWdata[3:0];
                end

                video_window_pkg::IDX_CAPTURE_MISC: begin
                    st_next.captureMiscLow = ioWdata[3:0];
                end

                video_window_pkg::IDX_BUF2_BYTE0: begin
                    st_next.buf2Byte0 = ioWdata;
                end

                video_window_pkg::IDX_BUF2_BYTE1: begin
                    st_next.buf2Byte1 = ioWdata;
                end

                video_window_pkg::IDX_PIXEL_ALIGN: begin
                    st_next.pixelAlign = ioWdata[3:0];
                end
                default: begin
                end
            endcase
        end
        // read data is captured so the port value stays stable
        if (ioRd) begin
            st_next.readData = ioSel ? readValue : st_reg.index;
        end
        // without double buffering buffer 1 always displays
        if (!dblBufEn) begin
            st_next.dispSel = 1'b0;
        end else if (bufferFlip) begin
            st_next.dispSel = !st_reg.dispSel;
        end
    end

    // ****************************************
    // registers
    // ****************************************

    // synchronous reset clears the whole slice
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_reg <= '{
                index: video_window_pkg::BYTE_RESET,
                region1Low: video_window_pkg::BYTE_RESET,
                region2WidthLow: video_window_pkg::BYTE_RESET,
                region2SrcLow: video_window_pkg::BYTE_RESET,
                horizOvf: video_window_pkg::HOVF_RESET,
                topLineLow: video_window_pkg::BYTE_RESET,
                bottomLineLow: video_window_pkg::BYTE_RESET,
                vertOvf: video_window_pkg::NIBBLE_RESET,
                buf1Byte0: video_window_pkg::BYTE_RESET,
                buf1Byte1: video_window_pkg::BYTE_RESET,
                buf1High: video_window_pkg::NIBBLE_RESET,
                captureMiscLow: video_window_pkg::NIBBLE_RESET,
                buf2Byte0: video_window_pkg::BYTE_RESET,
                buf2Byte1: video_window_pkg::BYTE_RESET,
                pixelAlign: video_window_pkg::NIBBLE_RESET,
                readData: video_window_pkg::BYTE_RESET,
                dispSel: 1'b0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // scan position
    // ****************************************

    // geometry is live: a write mid-line takes effect at once, except the region 2 source size, which loads at line start,
    // so software should update it during vertical blanking
    window_scan_tracker #(
        .GW(video_window_pkg::GEOM_W)
    ) u_tracker (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .frameStart(frameStart),
        .lineStart(lineStart),
        .dwordSlot(dwordSlot),
        .videoSlot(videoSlot),
        .region1Size(region1Size),
        .region2Width(region2Width),
        .region2SourceDwords(region2SourceDwords),
        .windowTopLine(windowTopLine),
        .windowBottomLine(windowBottomLine),
        .windowLine(windowLine),
        .windowShow(windowShow),
        .graphicsFetch(graphicsFetch),
        .videoFetch(videoFetch)
    );

endmodule
`default_nettype wire

// File: sim/video_window_geometry_regs_asserts.sv
// assertion checker for the video window register slice
`timescale 1ns/1ps
`default_nettype none
module video_window_geometry_regs_asserts (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic dblBufEn,
    input wire logic bufferFlip,
    input wire logic frameStart,
    input wire logic lineStart,
    input wire logic dwordSlot,
    input wire logic videoSlot,
    input wire logic [9:0] region2Width,
    input wire logic [9:0] region2SourceDwords,
    input wire logic [9:0] windowTopLine,
    input wire logic [9:0] windowBottomLine,
    input wire logic [21:0] buffer1Start,
    input wire logic [21:0] buffer2Start,
    input wire logic [21:0] displayBase,
    input wire logic [21:0] captureBase,
    input wire logic displayIsBuffer2,
    input wire logic windowLine,
    input wire logic windowShow,
    input wire logic graphicsFetch,
    input wire logic videoFetch
);
    // ********************
    // per-line counters
    // ********************
    logic [10:0] vCnt;
    logic [10:0] sCnt;
    // restart each scanline
    always_ff @(posedge ref_clk) begin
        if (!rst_n || frameStart || lineStart) begin
            vCnt <= '0;
            sCnt <= '0;
        end else begin
            vCnt <= vCnt + 11'(videoFetch);
            sCnt <= sCnt + 11'(dwordSlot && windowShow);
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ********************
    // properties
    // ********************
    property p_cap_align; captureBase[1:0] == 2'h0; endproperty
    a_cap_align: assert property (p_cap_align)
        else $error("capture unaligned");
    property p_disp_b1;
        !displayIsBuffer2 |-> displayBase == buffer1Start
            && captureBase == {buffer2Start[21:2], 2'h0};
    endproperty
    a_disp_b1: assert property (p_disp_b1)
        else $error("buffer 1 roles");
    property p_disp_b2;
        displayIsBuffer2 |-> displayBase == buffer2Start
            && captureBase == {buffer1Start[21:2], 2'h0};
    endproperty
    a_disp_b2: assert property (p_disp_b2)
        else $error("buffer 2 roles");
    property p_dbl_off; !dblBufEn |=> !displayIsBuffer2; endproperty
    a_dbl_off: assert property (p_dbl_off)
        else $error("buffer 2 kept while disabled");
    property p_flip;
        dblBufEn && bufferFlip |=> displayIsBuffer2 != $past(displayIsBuffer2);
    endproperty
    a_flip: assert property (p_flip)
        else $error("flip lost");
    property p_vfetch; videoFetch |-> videoSlot && windowLine; endproperty
    a_vfetch: assert property (p_vfetch)
        else $error("stray video fetch");
    property p_vcount; vCnt <= 11'(region2SourceDwords); endproperty
    a_vcount: assert property (p_vcount)
        else $error("too many source dwords");
    property p_skip; windowShow && dwordSlot |-> !graphicsFetch; endproperty
    a_skip: assert property (p_skip)
        else $error("fetch under window");
    property p_skip_count; sCnt <= 11'(region2Width); endproperty
    a_skip_count: assert property (p_skip_count)
        else $error("window too wide");
    property p_show;
        windowShow |-> windowLine && windowTopLine <= windowBottomLine;
    endproperty
    a_show: assert property (p_show)
        else $error("window off its lines");
    property p_gfetch; graphicsFetch |-> dwordSlot; endproperty
    a_gfetch: assert property (p_gfetch)
        else $error("fetch without slot");
    c_flip: cover property (dblBufEn && bufferFlip);
    c_show: cover property (windowShow && dwordSlot);
    c_video: cover property (videoFetch);
endmodule
bind video_window_geometry_regs video_window_geometry_regs_asserts i_chk (.*);
`default_nettype wire

// File: sim/display_memory_model.sv
// display memory side: scan timing, fetch slots and per-line counts
`timescale 1ns/1ps
`default_nettype none
module display_memory_model #(
    parameter int LINES = 4,
    parameter int SLOTS = 8
) (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic graphicsFetch,
    input wire logic videoFetch,
    output logic frameStart,
    output logic lineStart,
    output logic dwordSlot,
    output logic videoSlot,
    output logic lineDone,
    output logic [7:0] gfxCnt,
    output logic [7:0] vidCnt
);
    // fetches since line start
    always_ff @(posedge ref_clk) begin
        if (frameStart || lineStart) begin
            gfxCnt <= 8'h00;
            vidCnt <= 8'h00;
        end else begin
            gfxCnt <= gfxCnt + 8'(graphicsFetch);
            vidCnt <= vidCnt + 8'(videoFetch);
        end
    end
    // random gaps model a slow memory
    initial begin
        {frameStart, lineStart, dwordSlot, videoSlot, lineDone} = 5'h00;
        forever begin
            @(posedge ref_clk iff go);
            for (int n = 0; n < LINES; n++) begin
                @(posedge ref_clk);
                lineDone <= 1'b0;
                frameStart <= (n == 0);
                lineStart <= (n != 0);
                @(posedge ref_clk);
                frameStart <= 1'b0;
                lineStart <= 1'b0;
                for (int s = 0; s < SLOTS; s++) begin
                    repeat ($urandom % 2) begin
                        dwordSlot <= 1'b0;
                        videoSlot <= 1'b0;
                        @(posedge ref_clk);
                    end
                    dwordSlot <= 1'b1;
                    videoSlot <= 1'b1;
                    @(posedge ref_clk);
                end
                dwordSlot <= 1'b0;
                videoSlot <= 1'b0;
                lineDone <= 1'b1;
            end
            @(posedge ref_clk);
            lineDone <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the video window register slice
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    logic ref_clk = 1'b0, rst_n = 1'b0, ioSel = 1'b0, ioWr = 1'b0;
    logic ioRd = 1'b0, dblBufEn = 1'b0, bufferFlip = 1'b0, go = 1'b0;
    logic rdSeen = 1'b0;
    logic [7:0] ioWdata = 8'h00;
    logic frameStart, lineStart, dwordSlot, videoSlot, lineDone;
    logic [7:0] ioRdata, gfxCnt, vidCnt, e;
    logic [9:0] region1Size, region2Width, region2SourceDwords;
    logic [9:0] windowTopLine, windowBottomLine;
    logic [21:0] buffer1Start, buffer2Start, displayBase, captureBase;
    logic [21:0] b1Exp, b2Exp;
    logic [1:0] displayPixelSkip;
    logic displayIsBuffer2, windowLine, windowShow, graphicsFetch, videoFetch;
    logic [7:0] regv [0:255];
    logic [7:0] rdQ [$], gq [$], vq [$];
    int miscompares = 0, checked = 0;
    // indices and readable bits; the last is unmapped
    localparam logic [7:0] IDX [15] = '{8'h33, 8'h34, 8'h35, 8'h36, 8'h37,
        8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h58, 8'h59, 8'h5A, 8'h5D, 8'h40};
    localparam logic [7:0] MSK [15] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF,
        8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'hFF, 8'hFF, 8'h0F, 8'h00};
    always #50 ref_clk = ~ref_clk;
    video_window_geometry_regs i_dut (.*);
    display_memory_model #(.LINES(4), .SLOTS(8)) i_mem (.*);
    // index write, then a data access; reads queue their expectation
    task automatic acc(input logic [7:0] idx, input logic [7:0] d,
                       input logic w);
        @(posedge ref_clk);
        ioSel <= 1'b0;
        ioWr <= 1'b1;
        ioWdata <= idx;
        @(posedge ref_clk);
        ioSel <= 1'b1;
        ioWr <= w;
        ioRd <= !w;
        ioWdata <= d;
        if (!w) rdQ.push_back(d);
        @(posedge ref_clk);
        ioWr <= 1'b0;
        ioRd <= 1'b0;
    endtask
    // fields against bytes last written
    task automatic chkGeom(input logic sel);
        b1Exp = {regv[8'h3C][3:0], regv[8'h3B], regv[8'h3A], regv[8'h5D][3:2]};
        b2Exp = {regv[8'h58][3:0], regv[8'h5A], regv[8'h59], regv[8'h5D][3:2]};
        `CHK(region2SourceDwords, {regv[8'h36][5:4], regv[8'h35]})
        `CHK(region2Width, {regv[8'h36][3:2], regv[8'h34]})
        `CHK(region1Size, {regv[8'h36][1:0], regv[8'h33]})
        `CHK(windowTopLine, {regv[8'h39][1:0], regv[8'h37]})
        `CHK(windowBottomLine, {regv[8'h39][3:2], regv[8'h38]})
        `CHK(buffer1Start, b1Exp)
        `CHK(buffer2Start, b2Exp)
        `CHK(displayPixelSkip, regv[8'h5D][1:0])
        `CHK(displayIsBuffer2, sel)
        `CHK(displayBase, sel ? b2Exp : b1Exp)
        `CHK(captureBase, {sel ? b1Exp[21:2] : b2Exp[21:2], 2'h0})
    endtask
    // four-line frame, window on lines 1 and 2
    task automatic frame(input logic [7:0] r1, input logic [7:0] src);
        logic [7:0] v [7] = '{r1, 8'h03, src, 8'h00, 8'h01, 8'h02, 8'h00};
        for (int i = 0; i < 7; i++) acc(8'(8'h33 + i), v[i], 1'b1);
        for (int n = 0; n < 4; n++) begin
            gq.push_back((n == 1 || n == 2) ? 8'h05 : 8'h08);
            vq.push_back((n == 1 || n == 2) ? (src > 8 ? 8'h08 : src) : 8'h00);
        end
        @(posedge ref_clk);
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        for (int i = 0; i < 200 && gq.size() > 0; i++) @(posedge ref_clk);
    endtask
    task automatic end_sim();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // results settle by the falling edge
    always @(negedge ref_clk) begin
        if (rdSeen) begin
            e = rdQ.pop_front();
            `CHK(ioRdata, e)
        end
        rdSeen = ioRd;
        if (lineDone) begin
            e = gq.pop_front();
            `CHK(gfxCnt, e)
            e = vq.pop_front();
            `CHK(vidCnt, e)
        end
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h426F));
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 15; i++) acc(IDX[i], 8'h00, 1'b0);
        for (int i = 0; i < 15; i++) begin
            regv[IDX[i]] = 8'($urandom);
            acc(IDX[i], regv[IDX[i]], 1'b1);
        end
        // reserved and unmapped bits read zero
        for (int i = 0; i < 15; i++) acc(IDX[i], regv[IDX[i]] & MSK[i], 1'b0);
        @(negedge ref_clk);
        chkGeom(1'b0);
        // three flips enabled, then one refused
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            dblBufEn <= (i < 3);
            bufferFlip <= 1'b1;
            @(posedge ref_clk);
            bufferFlip <= 1'b0;
            @(negedge ref_clk);
            chkGeom(i == 0 || i == 2);
        end
        frame(8'h02, 8'h04);
        frame(8'h00, 8'h09);
        end_sim();
    end
endmodule
`default_nettype wire
